// ---- pkg/ubdl_defines.vh ----
// constants of the baud divisor latch block
// ----------------------------------------------------------------
// Function
// - whole divisor field is 16 bits read/write, resets to zero, upper bits unused
// - fraction divisor field is 6 bits read/write, resets to zero, upper bits unused
// - whole field zero means divide by one, fraction field ignored
// - new divisor applies only after the character in progress completes
// - divisors captured toward the baud generator only on line control write strobe
// - unused upper bits read undefined here zero; software preserves them
// - line control register holds word length, parity and stop bit settings
// ----------------------------------------------------------------
`ifndef UBDL_DEFINES_VH
`define UBDL_DEFINES_VH
`define UBDL_OFS_WHOLE    12'h024
`define UBDL_OFS_FRACTION 12'h028
`define UBDL_OFS_LINE     12'h02c
`define UBDL_OFS_ACTIVE   12'h030
`define UBDL_WHOLE_W      16
`define UBDL_FRACTION_W   6
`define UBDL_LINE_W       8
`define UBDL_WHOLE_RST    16'h0000
`define UBDL_FRACTION_RST 6'h00
`define UBDL_LINE_RST     8'h00
`define UBDL_MIN_WHOLE    16'h0001
`define UBDL_HTRANS_NSEQ  2'h2
`define UBDL_HTRANS_SEQ   2'h3
`endif

// ---- src/ubdl_apply_stage.v ----
// pending and active divisor stage that waits for the character boundary
`timescale 1ns/10ps
`include "ubdl_defines.vh"
module ubdl_apply_stage
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        capture,
  input  wire [15:0] whole_in,
  input  wire [5:0]  fraction_in,
  input  wire        char_busy,
  output reg  [15:0] active_whole,
  output reg  [5:0]  active_fraction,
  output reg         pending
);
  reg [15:0] held_whole;
  reg [5:0]  held_fraction;

  // ----------------------------------------------------------------
  // capture and apply
  // ----------------------------------------------------------------
  // a capture during a character is held; it lands once the line goes idle
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      held_whole      <= `UBDL_WHOLE_RST;
      held_fraction   <= `UBDL_FRACTION_RST;
      active_whole    <= `UBDL_MIN_WHOLE;
      active_fraction <= `UBDL_FRACTION_RST;
      pending         <= 1'b0;
    end
    else
    begin
      if (capture)
      begin
        held_whole    <= whole_in;
        held_fraction <= fraction_in;
        pending       <= 1'b1;
      end
      else if (pending && !char_busy)
      begin
        pending <= 1'b0;
        if (held_whole == 16'h0000)
        begin
          active_whole    <= `UBDL_MIN_WHOLE;
          active_fraction <= `UBDL_FRACTION_RST;
        end
        else
        begin
          active_whole    <= held_whole;
          active_fraction <= held_fraction;
        end
      end
    end
  end
endmodule // ubdl_apply_stage

// ---- src/ubdl_top.v ----
// baud divisor registers, line control and ahb-lite slave
`timescale 1ns/10ps
`include "ubdl_defines.vh"
module ubdl_top
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  input  wire        char_busy,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [15:0] baud_whole,
  output reg  [5:0]  baud_fraction,
  output reg  [7:0]  line_control,
  output reg         divisor_pending
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [15:0] divisor_whole_field;
  reg  [5:0]  divisor_fraction_field;
  reg  [11:0] dp_addr;
  reg         dp_write;
  reg         dp_read;
  reg         sync_a;
  reg         char_busy_s;
  reg         capture;
  wire [15:0] act_whole;
  wire [5:0]  act_fraction;
  wire        act_pending;
  wire        addr_phase;
  wire        fwd_hit;

  // word address of a byte address; both bus phases decode with it
  function [11:0] ubdl_word;
    input [11:0] byte_addr;
    begin
      ubdl_word = {byte_addr[11:2], 2'b00};
    end
  endfunction

  assign addr_phase = hsel && hready && (htrans == `UBDL_HTRANS_NSEQ || htrans == `UBDL_HTRANS_SEQ);
  // a read right behind a write to the same word must see the new value, not the stale one
  assign fwd_hit    = dp_write && (dp_addr == ubdl_word(haddr));

  // char_busy comes from the serial shifter, possibly on another clock
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync_a      <= 1'b0;
      char_busy_s <= 1'b0;
    end
    else
    begin
      sync_a      <= char_busy;
      char_busy_s <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // zero wait states; every access answers okay, unmapped reads return zero
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      dp_addr   <= 12'h000;
      dp_write  <= 1'b0;
      dp_read   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dp_addr   <= ubdl_word(haddr);
      dp_write  <= addr_phase && hwrite;
      dp_read   <= addr_phase && !hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // register writes land in the data phase
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      divisor_whole_field    <= `UBDL_WHOLE_RST;
      divisor_fraction_field <= `UBDL_FRACTION_RST;
      line_control           <= `UBDL_LINE_RST;
      capture                <= 1'b0;
    end
    else
    begin
      capture <= 1'b0;
      if (dp_write)
      begin
        case (dp_addr)
          `UBDL_OFS_WHOLE:    divisor_whole_field    <= hwdata[15:0];
          `UBDL_OFS_FRACTION: divisor_fraction_field <= hwdata[5:0];
          `UBDL_OFS_LINE:
          begin
            line_control <= hwdata[7:0];
            capture      <= 1'b1;
          end
          default:            capture <= 1'b0;
        endcase
      end
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always @(posedge clk)
  begin
    if (sys_rst)
      hrdata <= 32'h00000000;
    else if (addr_phase && !hwrite)
    begin
      case (ubdl_word(haddr))
        `UBDL_OFS_WHOLE:    hrdata <= {16'h0000, (fwd_hit ? hwdata[15:0] : divisor_whole_field)};
        `UBDL_OFS_FRACTION: hrdata <= {26'h0000000, (fwd_hit ? hwdata[5:0] : divisor_fraction_field)};
        `UBDL_OFS_LINE:     hrdata <= {24'h000000, (fwd_hit ? hwdata[7:0] : line_control)};
        `UBDL_OFS_ACTIVE:   hrdata <= {9'h000, act_pending, act_fraction, act_whole};
        default:            hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // divisor apply
  // ----------------------------------------------------------------
  ubdl_apply_stage u_apply
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .capture         (capture),
    .whole_in        (divisor_whole_field),
    .fraction_in     (divisor_fraction_field),
    .char_busy       (char_busy_s),
    .active_whole    (act_whole),
    .active_fraction (act_fraction),
    .pending         (act_pending)
  );

  // outputs straight from flops
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      baud_whole      <= `UBDL_MIN_WHOLE;
      baud_fraction   <= `UBDL_FRACTION_RST;
      divisor_pending <= 1'b0;
    end
    else
    begin
      baud_whole      <= act_whole;
      baud_fraction   <= act_fraction;
      divisor_pending <= act_pending;
    end
  end
endmodule // ubdl_top

// ---- verif/ubdl_chk.sv ----
// port checker for the baud divisor latch
`timescale 1ns/10ps
module ubdl_chk
(
  input wire        clk,
  input wire        sys_rst,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        char_busy,
  input wire [31:0] hrdata,
  input wire [15:0] baud_whole,
  input wire [5:0]  baud_fraction,
  input wire [7:0]  line_control,
  input wire        divisor_pending
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire go = hsel & hready & htrans[1];
  wire lcr_wr = go & hwrite & (haddr == 12'h02c);
  wire rd_w = go & ~hwrite & (haddr == 12'h024);
  wire rd_f = go & ~hwrite & (haddr == 12'h028);
  whole_rsvd_a: assert property (rd_w |=> hrdata[31:16] == 16'h0000)
    else $error("whole upper bits");
  frac_rsvd_a: assert property (rd_f |=> hrdata[31:6] == 26'h0)
    else $error("fraction upper bits");
  whole_min_a: assert property (baud_whole != 16'h0000)
    else $error("whole divisor zero");
  busy_hold_a: assert property (char_busy[*4] |=> $stable(baud_whole) && $stable(baud_fraction))
    else $error("divisor moved mid character");
  pend_clear_a: assert property (divisor_pending && !char_busy && $past(!char_busy, 2) && !$past(lcr_wr) && !$past(lcr_wr, 2) |-> ##[1:3] !divisor_pending)
    else $error("pending never applied");
  capture_src_a: assert property ($rose(divisor_pending) |-> $past(lcr_wr, 4))
    else $error("capture without line write");
  lcr_store_a: assert property (lcr_wr ##1 1 |=> line_control == $past(hwdata[7:0]))
    else $error("line control not stored");
  pair_apply_a: assert property ($changed({baud_whole, baud_fraction}) |-> $past(divisor_pending) || $past(divisor_pending, 2))
    else $error("divisor changed without capture");
endmodule // ubdl_chk
bind ubdl_top ubdl_chk ubdl_chk_i
(
  .clk             (clk),
  .sys_rst         (sys_rst),
  .hsel            (hsel),
  .haddr           (haddr),
  .htrans          (htrans),
  .hwrite          (hwrite),
  .hwdata          (hwdata),
  .hready          (hready),
  .char_busy       (char_busy),
  .hrdata          (hrdata),
  .baud_whole      (baud_whole),
  .baud_fraction   (baud_fraction),
  .line_control    (line_control),
  .divisor_pending (divisor_pending)
);

// ---- verif/ubdl_bench.sv ----
// self-checking bench for the baud divisor latch
`timescale 1ns/10ps
module ubdl_bench;
  reg         clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, char_busy = 1'b0;
  reg  [11:0] haddr = 12'h000;
  reg  [1:0]  htrans = 2'h0;
  reg  [31:0] hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, divisor_pending;
  wire [15:0] baud_whole;
  wire [5:0]  baud_fraction;
  wire [7:0]  line_control;
  integer     bad_count = 0, n_checks = 0, k;
  // ----
  // bus and compare tasks
  // ----
  initial forever #2.5 clk = ~clk;
  ubdl_top ubdl_top_i
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (3'h2),
    .hwdata          (hwdata),
    .hready          (hreadyout),
    .char_busy       (char_busy),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .baud_whole      (baud_whole),
    .baud_fraction   (baud_fraction),
    .line_control    (line_control),
    .divisor_pending (divisor_pending)
  );
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // hready is sampled at each edge; a stuck slave ends the run
  task rdy;
  begin
    @(posedge clk);
    for (k = 0; hreadyout !== 1'b1 && k < 50; k = k + 1)
      @(posedge clk);
    if (k == 50)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH hreadyout exp 1 got %b", hreadyout);
      summarize;
    end
  end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
    chk("resp", 32'h0, {31'h0, hresp});
  end
  endtask
  task wait_baud(input [15:0] w, input [5:0] f);
  begin
    for (k = 0; {baud_whole, baud_fraction} !== {w, f} && k < 20; k = k + 1)
      @(posedge clk);
    if (k == 20)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH baud wait exp %h got %h", {w, f}, {baud_whole, baud_fraction});
      summarize;
    end
    chk("baud", {10'h0, w, f}, {10'h0, baud_whole, baud_fraction});
  end
  endtask
  // ----
  // scenarios
  // ----
  task t_reset_values;
  begin
    chk("rst whole out", 32'h1, {16'h0, baud_whole});
    chk("rst frac out", 32'h0, {26'h0, baud_fraction});
    chk("rst line", 32'h0, {24'h0, line_control});
    chk("rst pending", 32'h0, {31'h0, divisor_pending});
    xfer(1'b0, 12'h024, 32'h0);
    chk("whole rst", 32'h0, rd);
    xfer(1'b0, 12'h028, 32'h0);
    chk("frac rst", 32'h0, rd);
    xfer(1'b0, 12'h02c, 32'h0);
    chk("line rst", 32'h0, rd);
  end
  endtask
  // software keeps the upper bits as read; only a line write moves the pair
  task t_capture;
  begin
    xfer(1'b0, 12'h024, 32'h0);
    xfer(1'b1, 12'h024, {rd[31:16], 16'h2345});
    xfer(1'b0, 12'h028, 32'h0);
    xfer(1'b1, 12'h028, {rd[31:6], 6'h27});
    xfer(1'b0, 12'h024, 32'h0);
    chk("whole rd", 32'h2345, rd);
    xfer(1'b0, 12'h028, 32'h0);
    chk("frac rd", 32'h27, rd);
    repeat (6) @(posedge clk);
    chk("no capture", 32'h1, {16'h0, baud_whole});
    xfer(1'b1, 12'h02c, 32'h60);
    wait_baud(16'h2345, 6'h27);
    chk("line", 32'h60, {24'h0, line_control});
    xfer(1'b0, 12'h02c, 32'h0);
    chk("line rd", 32'h60, rd);
    xfer(1'b0, 12'h030, 32'h0);
    chk("active", 32'h0027_2345, rd);
    xfer(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
  end
  endtask
  // busy line: the new pair must wait for the character to end
  task t_busy;
  begin
    char_busy <= 1'b1;
    xfer(1'b1, 12'h024, 32'h0);
    xfer(1'b1, 12'h028, 32'h5);
    xfer(1'b1, 12'h02c, 32'h3a);
    repeat (10) @(posedge clk);
    chk("held", {10'h0, 16'h2345, 6'h27}, {10'h0, baud_whole, baud_fraction});
    chk("pending", 32'h1, {31'h0, divisor_pending});
    xfer(1'b0, 12'h030, 32'h0);
    chk("active busy", 32'h0067_2345, rd);
    char_busy <= 1'b0;
    wait_baud(16'h1, 6'h0);
  end
  endtask
  // a reset in mid-run must return the whole, fraction and line registers and the outputs to reset values again; baud_whole comes back as 1
  task t_mid_reset;
  begin
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_values;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_values;
    t_capture;
    t_busy;
    t_mid_reset;
    summarize;
  end
endmodule // ubdl_bench
